// [src/mac_frame_statistics_counters.sv]
// Statistics counter bank of a 10/100 MAC with a classic Wishbone slave.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
module mac_frame_statistics_counters
    import stats_pkg::*;
#(
    parameter int LEN_W = 11
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Wishbone classic slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [31:0]      wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // Transmit outcome, valid with tx_done
    input  wire logic             tx_done,
    input  wire logic             tx_underrun,
    input  wire logic             tx_excess_col,
    input  wire logic [4:0]       tx_col_count,
    input  wire logic             tx_deferred,
    input  wire logic             tx_late_col,
    // Receive outcome, valid with rx_done
    input  wire logic             rx_done,
    input  wire logic             rx_addr_match,
    input  wire logic             rx_copied,
    input  wire logic [LEN_W-1:0] rx_length,
    input  wire logic             rx_crc_bad,
    input  wire logic             rx_odd_bits,
    input  wire logic             rx_symbol_err,
    // Interrupt
    output logic                  irq_o
);

    // ==========================================================
    // Elaboration checks
    // The length port must hold the big-frame limit.
    if (LEN_W < 11) begin : g_len_chk
        $error("LEN_W too small for frame lengths");
    end

    // ==========================================================
    // Helpers
    // All-ones mask of counter i within the widest counter.
    function automatic logic [CNT_MAXW-1:0] cnt_mask(input int i);
        cnt_mask = CNT_MAXW'((32'h1 << CNT_W[i]) - 32'h1);
    endfunction

    // Byte-lane merge of a write into an old word.
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  sel);
        lane_merge = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                lane_merge[8*b +: 8] = new_v[8*b +: 8];
            end
        end
    endfunction

    // ==========================================================
    // State
    typedef struct packed {
        logic [NUM_CNT-1:0][CNT_MAXW-1:0] cnt;
        logic [NUM_CNT-1:0]               stat;
        logic [NUM_CNT-1:0]               mask;
        logic                             rx_en;
        logic                             cnt_we;
        logic                             big;
        logic                             ack;
        logic [31:0]                      rdata;
        logic                             irq;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    logic               req;
    logic               rd_req;
    logic               wr_req;
    logic [NUM_CNT-1:0] hit;
    logic [NUM_CNT-1:0] inc;
    logic               tx_ok;
    logic               len_ok;
    logic [LEN_W-1:0]   max_len;

    // ==========================================================
    // Bus decode
    // A request is taken once; the registered ack ends it next cycle.
    assign req    = wb_cyc_i & wb_stb_i & ~s_r.ack;
    assign rd_req = req & ~wb_we_i;
    assign wr_req = req & wb_we_i;

    // One-hot hit of the counter words.
    // Addresses match in full, so an alias of a counter word is unmapped and reads zero.
    always_comb begin
        for (int i = 0; i < NUM_CNT; i++) begin
            hit[i] = (wb_adr_i == CNT_OFF[i]);
        end
    end

    // ==========================================================
    // Event classification
    // An underrun frame touches no other counter, so it gates all transmit terms.
    // The engines must hold a frame's fields valid in the cycle of its done pulse.
    assign tx_ok   = tx_done & ~tx_underrun & ~tx_excess_col;
    assign max_len = s_r.big ? LEN_W'(MAX_LEN_BIG) : LEN_W'(MAX_LEN);
    assign len_ok  = (rx_length >= LEN_W'(MIN_LEN)) && (rx_length <= max_len);

    // Per-counter increment pulses, one per completed frame.
    always_comb begin
        inc = '0;
        inc[IDX_TX_OK] = tx_ok;
        inc[IDX_ONE]   = tx_ok && (tx_col_count == 5'h01);
        inc[IDX_MANY]  = tx_ok && (tx_col_count >= 5'h02)
                         && (tx_col_count <= 5'(MANY_COL_MAX));
        // Late collisions are already inside tx_col_count, so they count twice.
        inc[IDX_LATE]  = tx_done & ~tx_underrun & tx_late_col;
        inc[IDX_DEFER] = tx_done & tx_deferred & ~tx_underrun
                         & (tx_col_count == 5'h00);
        inc[IDX_EXCESS] = tx_done & ~tx_underrun & tx_excess_col;
        // Receive terms advance only while reception is enabled.
        inc[IDX_RX_OK] = s_r.rx_en & rx_done & rx_addr_match & rx_copied & len_ok
                         & ~rx_crc_bad & ~rx_odd_bits & ~rx_symbol_err;
        inc[IDX_FCS]   = s_r.rx_en & rx_done & len_ok & ~rx_odd_bits
                         & (rx_crc_bad | rx_symbol_err);
        inc[IDX_ALIGN] = s_r.rx_en & rx_done & len_ok & rx_odd_bits
                         & (rx_crc_bad | rx_symbol_err);
    end

    // ==========================================================
    // Next state
    // A frame event in the cycle of a read or write is added on top, never lost.
    always_comb begin
        logic [CNT_MAXW-1:0] base;
        logic [31:0]         wval;
        logic [31:0]         cval;
        logic [31:0]         mval;
        logic [NUM_CNT-1:0]  sat_ev;
        base   = '0;
        wval   = lane_merge(32'h0, wb_dat_i, wb_sel_i);
        cval   = '0;
        mval   = lane_merge({23'h0, s_r.mask}, wb_dat_i, wb_sel_i);
        sat_ev = '0;
        s_nxt  = s_r;
        s_nxt.ack   = req;
        s_nxt.rdata = s_r.rdata;
        // Every taken access starts from zero data, so a write is acked with zero.
        if (req) begin
            s_nxt.rdata = RDATA_RST;
        end
        for (int i = 0; i < NUM_CNT; i++) begin
            base = s_r.cnt[i];
            // Unselected byte lanes keep their old count.
            cval = lane_merge({8'h00, s_r.cnt[i]}, wb_dat_i, wb_sel_i);
            if (rd_req && hit[i]) begin
                s_nxt.rdata = {8'h00, s_r.cnt[i] & cnt_mask(i)};
                base = '0;
            end else if (wr_req && hit[i] && s_r.cnt_we) begin
                base = cval[CNT_MAXW-1:0] & cnt_mask(i);
            end
            // Saturate rather than wrap, so a slow reader sees a pinned value.
            if (inc[i] && (base != cnt_mask(i))) begin
                base = base + 1'b1;
                sat_ev[i] = (base == cnt_mask(i));
            end
            s_nxt.cnt[i] = base;
        end
        // Own control words.
        if (rd_req && (wb_adr_i == CTRL_OFF)) begin
            s_nxt.rdata[CTRL_RX_EN_BIT]  = s_r.rx_en;
            s_nxt.rdata[CTRL_CNT_WE_BIT] = s_r.cnt_we;
        end
        if (rd_req && (wb_adr_i == CFG_OFF)) begin
            s_nxt.rdata[CFG_BIG_BIT] = s_r.big;
        end
        if (rd_req && (wb_adr_i == IRQ_MASK_OFF)) begin
            s_nxt.rdata[NUM_CNT-1:0] = s_r.mask;
        end
        if (wr_req && (wb_adr_i == CTRL_OFF)) begin
            s_nxt.rx_en  = wval[CTRL_RX_EN_BIT] | (s_r.rx_en & ~wb_sel_i[0]);
            s_nxt.cnt_we = wval[CTRL_CNT_WE_BIT] | (s_r.cnt_we & ~wb_sel_i[0]);
        end
        if (wr_req && (wb_adr_i == CFG_OFF)) begin
            s_nxt.big = wval[CFG_BIG_BIT] | (s_r.big & ~wb_sel_i[1]);
        end
        if (wr_req && (wb_adr_i == IRQ_MASK_OFF)) begin
            s_nxt.mask = mval[NUM_CNT-1:0];
        end
        // Status is cleared by its read; a saturation in that cycle stays set.
        if (rd_req && (wb_adr_i == IRQ_STAT_OFF)) begin
            s_nxt.rdata[NUM_CNT-1:0] = s_r.stat;
            s_nxt.stat = sat_ev;
        end else begin
            s_nxt.stat = s_r.stat | sat_ev;
        end
        s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
    end

    // ==========================================================
    // State register
    // Reset is synchronous and brings back zero counts with receive counting off.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r        <= '0;
            s_r.mask   <= MASK_RST;
            s_r.rdata  <= RDATA_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_dat_o = s_r.rdata;
    assign wb_ack_o = s_r.ack;
    assign irq_o    = s_r.irq;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence rd_of(int i);
        rd_req && hit[i];
    endsequence

    sequence quiet_inc(int i);
        inc[i] && !(req && hit[i]) && (s_r.cnt[i] != cnt_mask(i));
    endsequence

    tx_ok_count_a: assert property (quiet_inc(IDX_TX_OK) |=>
        s_r.cnt[IDX_TX_OK] == $past(s_r.cnt[IDX_TX_OK]) + 24'h1)
        else $error("good transmit frame not counted");

    one_col_a: assert property (tx_ok && tx_col_count == 5'h01 |-> inc[IDX_ONE])
        else $error("single collision frame missed");

    many_col_a: assert property (inc[IDX_MANY] |-> tx_done && !tx_underrun
        && tx_col_count >= 5'h02 && tx_col_count <= 5'h0f)
        else $error("multi collision count wrong");

    rx_good_a: assert property (inc[IDX_RX_OK] |-> rx_addr_match && rx_copied
        && !rx_crc_bad && rx_length >= 11'd64 && rx_length <= (s_r.big ? 11'd1536 : 11'd1518))
        else $error("bad frame counted as good");

    fcs_err_a: assert property (rx_done && s_r.rx_en && len_ok && !rx_odd_bits
        && (rx_crc_bad || rx_symbol_err) |-> inc[IDX_FCS] && !inc[IDX_ALIGN])
        else $error("frame check error missed");

    align_err_a: assert property (rx_done && s_r.rx_en && len_ok && rx_odd_bits
        && (rx_crc_bad || rx_symbol_err) |-> inc[IDX_ALIGN] && !inc[IDX_FCS])
        else $error("alignment error missed");

    defer_count_a: assert property (inc[IDX_DEFER] |-> tx_col_count == 5'h00
        && !tx_underrun && tx_deferred)
        else $error("deferral counted with collision or underrun");

    late_col_a: assert property (quiet_inc(IDX_LATE) |=>
        s_r.cnt[IDX_LATE] == $past(s_r.cnt[IDX_LATE]) + 24'h1)
        else $error("late collision not counted");

    read_clear_a: assert property (rd_of(IDX_MANY) ##0 !inc[IDX_MANY] |=>
        s_r.cnt[IDX_MANY] == 24'h0 ##1 !wb_ack_o)
        else $error("read did not clear counter");

    saturate_a: assert property (s_r.cnt[IDX_ONE] == 24'h00ffff
        && !(req && hit[IDX_ONE]) |=> s_r.cnt[IDX_ONE] == 24'h00ffff)
        else $error("counter wrapped past all ones");

    rx_gate_a: assert property (!s_r.rx_en |->
        inc[IDX_RX_OK] == 1'b0 && inc[IDX_FCS] == 1'b0 && inc[IDX_ALIGN] == 1'b0)
        else $error("receive counter moved while disabled");

    wr_ignore_a: assert property (wr_req && hit[IDX_FCS] && !s_r.cnt_we
        && !inc[IDX_FCS] |=> $stable(s_r.cnt[IDX_FCS]))
        else $error("counter write taken while disabled");

    excess_col_a: assert property (tx_done && tx_excess_col && !tx_underrun
        |-> inc[IDX_EXCESS] && !inc[IDX_TX_OK])
        else $error("excess collision frame miscounted");

    upper_zero_a: assert property (rd_of(IDX_FCS) |=> wb_ack_o && wb_dat_o[31:8] == 24'h0)
        else $error("upper bits of counter word not zero");

    // Bus handshake and control words.
    // A taken request is answered once and then drops, so one read clears once.
    sequence ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    sequence ctrl_write;
        wr_req && (wb_adr_i == CTRL_OFF) && wb_sel_i[0];
    endsequence

    ack_pulse_a: assert property (req |=> ack_once)
        else $error("ack not a single pulse");

    write_zero_a: assert property (wr_req |=> wb_dat_o == 32'h0)
        else $error("write acked with nonzero data");

    read_value_a: assert property (rd_of(IDX_TX_OK) |=>
        wb_dat_o == {8'h00, $past(s_r.cnt[IDX_TX_OK])})
        else $error("read returned wrong count");

    we_bit_a: assert property (ctrl_write |=>
        s_r.cnt_we == $past(wb_dat_i[CTRL_CNT_WE_BIT]))
        else $error("counter write enable not stored");

    rx_enable_a: assert property (ctrl_write |=>
        s_r.rx_en == $past(wb_dat_i[CTRL_RX_EN_BIT]))
        else $error("receive enable not stored");

    cfg_big_a: assert property (wr_req && wb_adr_i == CFG_OFF && wb_sel_i[1] |=>
        s_r.big == $past(wb_dat_i[CFG_BIG_BIT]))
        else $error("big frame bit not stored");

    wr_take_a: assert property (wr_req && hit[IDX_FCS] && s_r.cnt_we
        && wb_sel_i == 4'hf && !inc[IDX_FCS] |=>
        s_r.cnt[IDX_FCS] == {16'h0000, $past(wb_dat_i[7:0])})
        else $error("enabled counter write not stored");

    // Frame classification.
    underrun_quiet_a: assert property (tx_done && tx_underrun |->
        !inc[IDX_TX_OK] && !inc[IDX_ONE] && !inc[IDX_MANY]
        && !inc[IDX_DEFER] && !inc[IDX_LATE] && !inc[IDX_EXCESS])
        else $error("underrun frame counted");

    late_twice_a: assert property (tx_ok && tx_late_col && tx_col_count == 5'h01
        |-> inc[IDX_LATE] && inc[IDX_ONE])
        else $error("late collision not counted twice");

    defer_col_a: assert property (tx_done && tx_col_count != 5'h00 |->
        !inc[IDX_DEFER])
        else $error("deferral counted with collision");

    rx_need_a: assert property (rx_done && !(rx_addr_match && rx_copied) |->
        !inc[IDX_RX_OK])
        else $error("unmatched or uncopied frame counted");

    len_gate_a: assert property (!len_ok |->
        !inc[IDX_RX_OK] && !inc[IDX_FCS] && !inc[IDX_ALIGN])
        else $error("frame of invalid length counted");

    err_not_good_a: assert property (inc[IDX_FCS] || inc[IDX_ALIGN] |->
        !inc[IDX_RX_OK])
        else $error("errored frame counted as good");

    // Saturation flag and interrupt level.
    sat_flag_a: assert property (inc[IDX_FCS] && s_r.cnt[IDX_FCS] == 24'h0000fe
        && !(req && hit[IDX_FCS]) |=> s_r.stat[IDX_FCS])
        else $error("saturation not flagged");

    irq_level_a: assert property (irq_o == (|(s_r.stat & s_r.mask)))
        else $error("interrupt level wrong");

endmodule

// [src/stats_pkg.sv]
// Constants for the MAC frame statistics counter bank.
package stats_pkg;
    // ==========================================================
    // Counter bank layout
    localparam int NUM_CNT   = 9;
    localparam int CNT_MAXW  = 24;
    localparam int IDX_TX_OK = 0;
    localparam int IDX_ONE   = 1;
    localparam int IDX_MANY  = 2;
    localparam int IDX_RX_OK = 3;
    localparam int IDX_FCS   = 4;
    localparam int IDX_ALIGN = 5;
    localparam int IDX_DEFER = 6;
    localparam int IDX_LATE  = 7;
    localparam int IDX_EXCESS = 8;

    // ==========================================================
    // Register byte addresses
    localparam logic [31:0] TX_OK_OFF     = 32'hf802c040;
    localparam logic [31:0] ONE_COL_OFF   = 32'hf802c044;
    localparam logic [31:0] MANY_COL_OFF  = 32'hf802c048;
    localparam logic [31:0] RX_OK_OFF     = 32'hf802c04c;
    localparam logic [31:0] FCS_ERR_OFF   = 32'hf802c050;
    localparam logic [31:0] ALIGN_ERR_OFF = 32'hf802c054;
    localparam logic [31:0] DEFER_OFF     = 32'hf802c058;
    localparam logic [31:0] LATE_COL_OFF  = 32'hf802c05c;
    localparam logic [31:0] EXCESS_OFF    = 32'hf802c060;
    localparam logic [31:0] CTRL_OFF      = 32'hf802c0f0;
    localparam logic [31:0] CFG_OFF       = 32'hf802c0f4;
    localparam logic [31:0] IRQ_STAT_OFF  = 32'hf802c0f8;
    localparam logic [31:0] IRQ_MASK_OFF  = 32'hf802c0fc;
    localparam logic [31:0] CNT_OFF [NUM_CNT] = '{TX_OK_OFF, ONE_COL_OFF, MANY_COL_OFF,
        RX_OK_OFF, FCS_ERR_OFF, ALIGN_ERR_OFF, DEFER_OFF, LATE_COL_OFF, EXCESS_OFF};
    localparam int CNT_W [NUM_CNT] = '{24, 16, 16, 24, 8, 8, 16, 8, 8};

    // ==========================================================
    // Control and configuration fields, reset values
    localparam int CTRL_RX_EN_BIT  = 2;
    localparam int CTRL_CNT_WE_BIT = 7;
    localparam int CFG_BIG_BIT     = 8;
    localparam logic [NUM_CNT-1:0] MASK_RST = 9'h000;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;

    // ==========================================================
    // Frame limits
    localparam int MIN_LEN     = 64;
    localparam int MAX_LEN     = 1518;
    localparam int MAX_LEN_BIG = 1536;
    localparam int MANY_COL_MAX = 15;
endpackage

// [tb/mac_engine_model.sv]
// Behavioural model of the MAC transmit and receive engines that report frame outcomes.
`timescale 1ns/100ps
module mac_engine_model #(
    parameter int LEN_W = 11
) (
    // Clock
    input  wire logic             ref_clk,
    // Transmit outcome
    output logic                  tx_done,
    output logic                  tx_underrun,
    output logic                  tx_excess_col,
    output logic [4:0]            tx_col_count,
    output logic                  tx_deferred,
    output logic                  tx_late_col,
    // Receive outcome
    output logic                  rx_done,
    output logic                  rx_addr_match,
    output logic                  rx_copied,
    output logic [LEN_W-1:0]      rx_length,
    output logic                  rx_crc_bad,
    output logic                  rx_odd_bits,
    output logic                  rx_symbol_err
);
    // Quiet at time zero; the fields only mean something while a done pulse is high.
    initial begin
        {tx_done, rx_done} = 2'h0;
        {tx_underrun, tx_excess_col, tx_deferred, tx_late_col, tx_col_count} = 9'h000;
        {rx_addr_match, rx_copied, rx_crc_bad, rx_odd_bits, rx_symbol_err, rx_length} = '0;
    end

    // One-cycle transmit report; the fields flip afterwards so late sampling shows up.
    task automatic send_tx(input logic [4:0] col, input logic [3:0] flg);
        @(posedge ref_clk);
        tx_done <= 1'b1;
        {tx_underrun, tx_excess_col, tx_deferred, tx_late_col, tx_col_count} <= {flg, col};
        @(posedge ref_clk);
        tx_done <= 1'b0;
        {tx_underrun, tx_excess_col, tx_deferred, tx_late_col, tx_col_count} <= ~{flg, col};
    endtask

    // One-cycle receive report, with the same flip once the pulse is over.
    task automatic send_rx(input logic [4:0] flg, input logic [LEN_W-1:0] len);
        @(posedge ref_clk);
        rx_done <= 1'b1;
        {rx_addr_match, rx_copied, rx_crc_bad, rx_odd_bits, rx_symbol_err, rx_length} <= {flg, len};
        @(posedge ref_clk);
        rx_done <= 1'b0;
        {rx_addr_match, rx_copied, rx_crc_bad, rx_odd_bits, rx_symbol_err, rx_length} <= ~{flg, len};
    endtask
endmodule

// [tb/mac_frame_statistics_counters_test.sv]
// Self-checking bench for the frame statistics counter bank.
`timescale 1ns/100ps
module mac_frame_statistics_counters_test;
    import stats_pkg::*;
    // ==========================================================
    // Signals
    logic        ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
    logic [3:0]  wb_sel_i;
    logic        tx_done, tx_underrun, tx_excess_col, tx_deferred, tx_late_col;
    logic [4:0]  tx_col_count;
    logic        rx_done, rx_addr_match, rx_copied, rx_crc_bad, rx_odd_bits, rx_symbol_err;
    logic [10:0] rx_length;
    logic [31:0] exp_cnt [NUM_CNT];
    int          fails, samples_checked;

    mac_frame_statistics_counters dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_done(tx_done),
        .tx_underrun(tx_underrun), .tx_excess_col(tx_excess_col), .tx_col_count(tx_col_count),
        .tx_deferred(tx_deferred), .tx_late_col(tx_late_col), .rx_done(rx_done),
        .rx_addr_match(rx_addr_match), .rx_copied(rx_copied), .rx_length(rx_length),
        .rx_crc_bad(rx_crc_bad), .rx_odd_bits(rx_odd_bits), .rx_symbol_err(rx_symbol_err),
        .irq_o(irq_o));
    mac_engine_model eng (.ref_clk(ref_clk), .tx_done(tx_done), .tx_underrun(tx_underrun),
        .tx_excess_col(tx_excess_col), .tx_col_count(tx_col_count), .tx_deferred(tx_deferred),
        .tx_late_col(tx_late_col), .rx_done(rx_done), .rx_addr_match(rx_addr_match),
        .rx_copied(rx_copied), .rx_length(rx_length), .rx_crc_bad(rx_crc_bad),
        .rx_odd_bits(rx_odd_bits), .rx_symbol_err(rx_symbol_err));

    // ==========================================================
    // Shared tasks
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("MISMATCH t=%0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    // Classic single cycle; the request is held until ack is sampled high.
    task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, adr, wd};
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        check(32'(n), 32'h2, "ack latency");
        if (wb_ack_o !== 1'b1) begin
            wrap_up();
        end
    endtask

    task automatic rd_chk(input logic [31:0] adr, input logic [31:0] want, input string what);
        wb(1'b0, adr, 32'h0);
        check(rd, want, what);
    endtask

    // Reads every counter; a read clears it, so the expectation goes back to zero.
    task automatic check_all();
        for (int i = 0; i < NUM_CNT; i++) begin
            rd_chk(CNT_OFF[i], exp_cnt[i], "counter");
            exp_cnt[i] = 32'h0;
        end
    endtask

    // ==========================================================
    // Scenarios
    task automatic reset_values();
        check_all();
        rd_chk(CTRL_OFF, 32'h0, "control after reset");
        rd_chk(IRQ_STAT_OFF, 32'h0, "status after reset");
    endtask

    task automatic tx_classes();
        eng.send_tx(5'h00, 4'h0);
        eng.send_tx(5'h01, 4'h0);
        eng.send_tx(5'h02, 4'h0);
        eng.send_tx(5'h0f, 4'h0);
        eng.send_tx(5'h10, 4'h4);
        eng.send_tx(5'h01, 4'h8);
        eng.send_tx(5'h00, 4'ha);
        eng.send_tx(5'h01, 4'h1);
        eng.send_tx(5'h00, 4'h2);
        eng.send_tx(5'h03, 4'h2);
        exp_cnt[IDX_TX_OK] = 32'h7;
        exp_cnt[IDX_ONE] = 32'h2;
        exp_cnt[IDX_MANY] = 32'h3;
        exp_cnt[IDX_LATE] = 32'h1;
        exp_cnt[IDX_DEFER] = 32'h1;
        exp_cnt[IDX_EXCESS] = 32'h1;
        check_all();
    endtask

    task automatic rx_classes();
        eng.send_rx(5'h18, 11'h040);
        check_all();
        wb(1'b1, CTRL_OFF, 32'h4);
        eng.send_rx(5'h18, 11'h040);
        eng.send_rx(5'h18, 11'h5ee);
        eng.send_rx(5'h18, 11'h03f);
        eng.send_rx(5'h18, 11'h5ef);
        eng.send_rx(5'h08, 11'h064);
        eng.send_rx(5'h10, 11'h064);
        eng.send_rx(5'h1c, 11'h040);
        eng.send_rx(5'h19, 11'h5ee);
        eng.send_rx(5'h1e, 11'h064);
        eng.send_rx(5'h1b, 11'h064);
        eng.send_rx(5'h1c, 11'h5ef);
        wb(1'b1, CFG_OFF, 32'h100);
        eng.send_rx(5'h18, 11'h600);
        eng.send_rx(5'h1c, 11'h600);
        eng.send_rx(5'h18, 11'h601);
        exp_cnt[IDX_RX_OK] = 32'h3;
        exp_cnt[IDX_FCS] = 32'h3;
        exp_cnt[IDX_ALIGN] = 32'h2;
        check_all();
    endtask

    // Counter writes, saturation and the interrupt path on the frame check counter.
    task automatic write_sat_irq();
        wb(1'b1, FCS_ERR_OFF, 32'h12);
        rd_chk(FCS_ERR_OFF, 32'h0, "write while locked");
        wb(1'b1, CTRL_OFF, 32'h84);
        rd_chk(CTRL_OFF, 32'h84, "control");
        wb(1'b1, FCS_ERR_OFF, 32'hffff_ff12);
        rd_chk(FCS_ERR_OFF, 32'h12, "written value");
        wb(1'b1, FCS_ERR_OFF, 32'hfe);
        eng.send_rx(5'h1c, 11'h040);
        eng.send_rx(5'h1c, 11'h040);
        repeat (2) @(negedge ref_clk);
        check({31'h0, irq_o}, 32'h0, "irq while masked");
        wb(1'b1, IRQ_MASK_OFF, 32'h10);
        repeat (2) @(negedge ref_clk);
        check({31'h0, irq_o}, 32'h1, "irq unmasked");
        rd_chk(FCS_ERR_OFF, 32'hff, "saturated");
        rd_chk(FCS_ERR_OFF, 32'h0, "cleared by read");
        rd_chk(IRQ_STAT_OFF, 32'h10, "status");
        repeat (2) @(negedge ref_clk);
        check({31'h0, irq_o}, 32'h0, "irq after clear");
        rd_chk(CFG_OFF, 32'h100, "config");
        rd_chk(IRQ_MASK_OFF, 32'h10, "mask");
        wb(1'b1, ONE_COL_OFF, 32'h0000_ffff);
        eng.send_tx(5'h01, 4'h0);
        rd_chk(ONE_COL_OFF, 32'hffff, "held at all ones");
        wb(1'b1, 32'hf802c0ec, 32'h5a);
        rd_chk(32'hf802c0ec, 32'h0, "unmapped");
    endtask

    // ==========================================================
    // Clock, reset and main sequence
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    initial begin
        {rst, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
        {wb_adr_i, wb_dat_i} = 64'h0;
        wb_sel_i = 4'hf;
        fails = 0;
        samples_checked = 0;
        foreach (exp_cnt[i]) exp_cnt[i] = 32'h0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        reset_values();
        tx_classes();
        rx_classes();
        write_sat_irq();
        wrap_up();
    end
endmodule
